/* src/pbm_pkg.sv */
// Constants, codes and types shared by the parallel bus master engine.
// Assumes one 200 MHz system clock; control bits arrive as plain ports.

package pbm_pkg;
   // Master mode encodings
   localparam logic [1:0] PBM_MODE_SPLIT = 2'h2; // Separate read and write strobes
   localparam logic [1:0] PBM_MODE_COMBINED = 2'h3; // Direction plus enable strobe
   // Address multiplex encodings
   localparam logic [1:0] PBM_MUX_NONE = 2'h0; // Demultiplexed
   localparam logic [1:0] PBM_MUX_PARTIAL = 2'h1; // Low byte multiplexed
   localparam logic [1:0] PBM_MUX_FULL = 2'h2; // Both bytes multiplexed
   // Address step encodings
   localparam logic [1:0] PBM_STEP_INC = 2'h1; // Increment
   localparam logic [1:0] PBM_STEP_DEC = 2'h2; // Decrement
   // Pin positions
   localparam int PBM_CS_PIN = 14; // Chip select shares this address pin
   localparam int PBM_LATCH_LO_PIN = 0; // Low latch strobe pin
   localparam int PBM_LATCH_HI_PIN = 1; // High latch strobe pin
   localparam int PBM_CS_HI_BIT = 6; // Chip select bit inside high address byte
   // Widths and depth
   localparam int PBM_ADDR_PINS = 15; // Address pins 14..0
   localparam int PBM_BUF_DEPTH = 2; // Capture buffer entries
   localparam int PBM_BUF_WIDTH = 9; // Half select plus byte
   // Reset values
   localparam logic [15:0] PBM_ADDR_RESET = 16'h0000; // Address register
   localparam logic [15:0] PBM_DATA_RESET = 16'h0000; // Data-in register
   localparam logic [3:0] PBM_CNT_RESET = 4'h0; // Wait counter
   // Engine states
   typedef enum logic [2:0] {
      PBM_IDLE = 3'h0,
      PBM_ADDR_LO = 3'h1,
      PBM_ADDR_HI = 3'h2,
      PBM_SETUP = 3'h3,
      PBM_STROBE = 3'h4,
      PBM_HOLD = 3'h5
   } pbm_state_t;
endpackage

/* src/pbm_stream_if.sv */
// Valid/ready byte stream between the engine and its capture buffer.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
`default_nettype none
interface pbm_stream_if import pbm_pkg::*;;
   logic valid; // Word offered
   logic ready; // Word can be taken
   logic [PBM_BUF_WIDTH-1:0] data; // High-half flag and byte
   // Side that offers words
   modport producer (output valid, output data, input ready);
   // Side that takes words
   modport consumer (input valid, input data, output ready);
endinterface
`default_nettype wire

/* src/pbm_byte_buffer.sv */
// Two-entry flip-flop buffer for captured read bytes.
// Assumes synchronous active-low reset already released cleanly.
`timescale 1ns/10ps
`default_nettype none
module pbm_byte_buffer import pbm_pkg::*; (
   input wire logic clk, // System clock
   input wire logic rst_n, // Synchronised reset, active low
   pbm_stream_if.consumer fill, // Filling side
   pbm_stream_if.producer drain // Draining side
);
   logic [PBM_BUF_WIDTH-1:0] mem [PBM_BUF_DEPTH]; // Storage entries
   logic wr_ptr; // Next entry to fill
   logic rd_ptr; // Next entry to drain
   logic [1:0] count; // Entries held
   logic push; // Fill handshake
   logic pop; // Drain handshake

   // Honest full and empty
   assign fill.ready = (count != 2'h2);
   assign drain.valid = (count != 2'h0);
   assign drain.data = mem[rd_ptr];
   assign push = fill.valid && fill.ready;
   assign pop = drain.valid && drain.ready;

   // One storage flop group per entry
   for (genvar i = 0; i < PBM_BUF_DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            mem[i] <= '0;
         end else if (push && (wr_ptr == 1'(i))) begin
            mem[i] <= fill.data;
         end
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // pbm_byte_buffer
`default_nettype wire

/* src/pbm_master_engine.sv */
// Master engine of an 8-bit parallel port: address phases, waits, strobes.
// Assumes all inputs synchronous to CLK_SYS; software strobes are one cycle.
`timescale 1ns/10ps
`default_nettype none
module pbm_master_engine import pbm_pkg::*; (
   input wire logic CLK_SYS, // System clock
   input wire logic RSTN, // Asynchronous reset, active low
   input wire logic PORT_MODULE_ON, // Module enable
   input wire logic [1:0] MASTER_MODE, // Mode field
   input wire logic [1:0] ADDR_MUX_SELECT, // Address multiplexing
   input wire logic WORD_WIDTH_SELECT, // 1 = 16-bit data
   input wire logic [1:0] ADDR_STEP_MODE, // Address step mode
   input wire logic [1:0] SETUP_WAIT_COUNT, // Beginning waits
   input wire logic [3:0] STROBE_WAIT_COUNT, // Middle waits
   input wire logic [1:0] HOLD_WAIT_COUNT, // End waits
   input wire logic CS_IS_SELECT, // Pin 14 acts as chip select
   input wire logic CHIP_SELECT_POLARITY, // 1 = active high
   input wire logic BYTE_STROBE_POLARITY, // 1 = active high
   input wire logic WRITE_STROBE_POLARITY, // Write or enable, 1 = high
   input wire logic READ_STROBE_POLARITY, // Read or direction, 1 = high
   input wire logic LATCH_STROBE_POLARITY, // 1 = active high
   input wire logic BYTE_STROBE_PIN_ON, // Byte strobe pin enable
   input wire logic WRITE_STROBE_PIN_ON, // Write strobe pin enable
   input wire logic READ_STROBE_PIN_ON, // Read strobe pin enable
   input wire logic [14:0] ADDRESS_PIN_ON, // Address pin enables
   input wire logic ADDR_WRITE, // Load address register
   input wire logic [15:0] ADDR_WDATA, // Address to load
   output logic [15:0] BUS_ADDRESS_REG, // Address register
   input wire logic DIN_READ_LO, // Software read of low data byte
   input wire logic DIN_WRITE_LO, // Software write of low data byte
   input wire logic DIN_WRITE_HI, // Software write of high data byte
   input wire logic [7:0] DIN_WDATA, // Written byte
   output logic [15:0] DATA_IN_REG, // Data-in register
   output logic BUSY, // Operation in progress
   input wire logic IRQ_ENABLE, // Completion pulse enable
   output logic IRQ_PULSE, // Operation complete
   input wire logic [7:0] PORT_DATA_IN, // Data pins, input
   output logic [7:0] PORT_DATA_OUT, // Data pins, output
   output logic PORT_DATA_OE, // Data pins, drive enable
   output logic [14:0] PORT_ADDR_OUT, // Address pins
   output logic [14:0] PORT_ADDR_OE, // Address pin enables
   output logic READ_STROBE_OUT, // Read or direction pin
   output logic READ_STROBE_OE, // Its enable
   output logic WRITE_STROBE_OUT, // Write or enable pin
   output logic WRITE_STROBE_OE, // Its enable
   output logic HIGH_BYTE_STROBE_OUT, // Byte enable pin
   output logic HIGH_BYTE_STROBE_OE // Its enable
);
   logic [1:0] rst_sync; // Reset release chain
   logic rst_n; // Synchronised reset
   pbm_state_t state; // Engine state
   pbm_state_t next_state; // Next engine state
   logic [3:0] cnt; // Wait counter
   logic [3:0] next_cnt; // Next wait counter
   logic hi_byte; // Second byte of a word
   logic next_hi; // Next byte select
   logic op_read; // Current operation is a read
   logic master_on; // Enabled in a master mode
   logic mux_addr; // Any address multiplexing
   logic mux_full; // Full multiplexing
   logic start; // Accepted start request
   logic fin; // Last cycle of an operation
   logic byte_end; // Last cycle of a byte
   logic [3:0] setup_eff; // Setup waits after masking
   logic [3:0] hold_eff; // Hold waits after masking
   pbm_state_t data_state; // Entry state of a data phase
   logic [3:0] data_cnt; // Entry count of a data phase
   logic in_data; // In a data phase
   logic [7:0] cur_byte; // Byte being written
   logic [15:0] stepped; // Address after stepping
   logic lat_lo_lvl; // Low latch level
   logic lat_hi_lvl; // High latch level
   logic cs_lvl; // Chip select level
   pbm_stream_if cap_in (); // Engine to buffer
   pbm_stream_if cap_out (); // Buffer to register

   // Reset release through two flops
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Master operation gate
   assign master_on = PORT_MODULE_ON && MASTER_MODE[1];
   assign mux_full = (ADDR_MUX_SELECT == PBM_MUX_FULL);
   assign mux_addr = (ADDR_MUX_SELECT == PBM_MUX_PARTIAL) || mux_full;

   // Zero strobe wait cancels setup and hold waits
   assign setup_eff = (STROBE_WAIT_COUNT == 4'h0) ? 4'h0 : {2'h0, SETUP_WAIT_COUNT};
   assign hold_eff = (STROBE_WAIT_COUNT == 4'h0) ? 4'h0 : {2'h0, HOLD_WAIT_COUNT};

   // Data phase entry: setup waits, else straight to strobe
   always_comb begin
      if (setup_eff != 4'h0) begin
         data_state = PBM_SETUP;
         data_cnt = setup_eff - 4'h1;
      end else begin
         data_state = PBM_STROBE;
         data_cnt = STROBE_WAIT_COUNT;
      end
   end

   // Requests are ignored while busy
   assign start = master_on && (DIN_READ_LO || DIN_WRITE_LO) && !BUSY;

   // Next state of the bus sequence
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_hi = hi_byte;
      unique case (state)
         PBM_IDLE: begin
            next_state = PBM_IDLE;
         end
         PBM_ADDR_LO: begin
            // Low address byte, then high byte or data
            if (mux_full) begin
               next_state = PBM_ADDR_HI;
            end else begin
               next_state = data_state;
               next_cnt = data_cnt;
            end
         end
         PBM_ADDR_HI: begin
            next_state = data_state;
            next_cnt = data_cnt;
         end
         PBM_SETUP: begin
            // Count setup waits down
            if (cnt == 4'h0) begin
               next_state = PBM_STROBE;
               next_cnt = STROBE_WAIT_COUNT;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         PBM_STROBE: begin
            // Strobe lasts one plus middle waits; a full buffer stretches it
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else if ((!op_read || cap_in.ready) && (hold_eff != 4'h0)) begin
               next_state = PBM_HOLD;
               next_cnt = hold_eff - 4'h1;
            end
         end
         PBM_HOLD: begin
            // Hold waits count down; the last one ends the byte
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end
         end
         default: begin
            next_state = PBM_IDLE;
         end
      endcase
      // Second byte of a word, or the end of the operation
      if (byte_end) begin
         if (WORD_WIDTH_SELECT && !hi_byte) begin
            next_hi = 1'b1;
            next_state = data_state;
            next_cnt = data_cnt;
         end else begin
            next_state = PBM_IDLE;
         end
      end
      // A new request may follow in the last cycle
      if (start) begin
         next_hi = 1'b0;
         if (mux_addr) begin
            next_state = PBM_ADDR_LO;
         end else begin
            next_state = data_state;
            next_cnt = data_cnt;
         end
      end
      // Disable stops any operation
      if (!master_on) begin
         next_state = PBM_IDLE;
      end
   end

   // Byte and operation ends, kept out of the next-state process so busy cannot feed back
   assign byte_end = ((state == PBM_STROBE) && (cnt == 4'h0) && (!op_read || cap_in.ready) && (hold_eff == 4'h0))
      || ((state == PBM_HOLD) && (cnt == 4'h0));
   assign fin = byte_end && !(WORD_WIDTH_SELECT && !hi_byte) && master_on;

   // Busy in every cycle but the last
   assign BUSY = (state != PBM_IDLE) && !fin;

   // State, counter and byte select
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         state <= PBM_IDLE;
         cnt <= PBM_CNT_RESET;
         hi_byte <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         hi_byte <= next_hi;
      end
   end

   // Direction of the accepted operation; write wins a tie
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         op_read <= 1'b0;
      end else if (start) begin
         op_read <= !DIN_WRITE_LO;
      end
   end

   // Address stepping keeps the chip select bit
   always_comb begin
      unique case (ADDR_STEP_MODE)
         PBM_STEP_INC: stepped = BUS_ADDRESS_REG + 16'h0001;
         PBM_STEP_DEC: stepped = BUS_ADDRESS_REG - 16'h0001;
         default: stepped = BUS_ADDRESS_REG;
      endcase
      if (CS_IS_SELECT) begin
         stepped[PBM_CS_PIN] = BUS_ADDRESS_REG[PBM_CS_PIN];
      end
   end

   // Address register: step at completion, else software load
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         BUS_ADDRESS_REG <= PBM_ADDR_RESET;
      end else if (fin) begin
         BUS_ADDRESS_REG <= stepped;
      end else if (ADDR_WRITE) begin
         BUS_ADDRESS_REG <= ADDR_WDATA;
      end
   end

   // Captured byte offered at the last strobe cycle of a read
   assign cap_in.valid = (state == PBM_STROBE) && (cnt == 4'h0) && op_read;
   assign cap_in.data = {hi_byte, PORT_DATA_IN};
   // Software writes to the register stall the drain
   assign cap_out.ready = !(DIN_WRITE_LO || DIN_WRITE_HI);

   // Capture buffer
   pbm_byte_buffer u_buffer (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .fill(cap_in),
      .drain(cap_out)
   );

   // Data-in register: software bytes and drained bus bytes
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         DATA_IN_REG <= PBM_DATA_RESET;
      end else begin
         if (DIN_WRITE_LO && !BUSY) begin
            DATA_IN_REG[7:0] <= DIN_WDATA;
         end
         if (DIN_WRITE_HI) begin
            DATA_IN_REG[15:8] <= DIN_WDATA;
         end
         if (cap_out.valid && cap_out.ready) begin
            // First byte low half, second high half
            if (cap_out.data[8]) begin
               DATA_IN_REG[15:8] <= cap_out.data[7:0];
            end else begin
               DATA_IN_REG[7:0] <= cap_out.data[7:0];
            end
         end
      end
   end

   // Completion pulse, once per operation
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         IRQ_PULSE <= 1'b0;
      end else begin
         IRQ_PULSE <= fin && IRQ_ENABLE;
      end
   end

   // Data pin drive
   assign in_data = (state == PBM_SETUP) || (state == PBM_STROBE) || (state == PBM_HOLD);
   assign cur_byte = hi_byte ? DATA_IN_REG[15:8] : DATA_IN_REG[7:0];
   always_comb begin
      PORT_DATA_OUT = 8'h00;
      PORT_DATA_OE = 1'b0;
      if (state == PBM_ADDR_LO) begin
         PORT_DATA_OUT = BUS_ADDRESS_REG[7:0];
         PORT_DATA_OE = 1'b1;
      end else if (state == PBM_ADDR_HI) begin
         PORT_DATA_OUT = BUS_ADDRESS_REG[15:8];
         PORT_DATA_OUT[PBM_CS_HI_BIT] = BUS_ADDRESS_REG[PBM_CS_PIN] && !CS_IS_SELECT;
         PORT_DATA_OE = 1'b1;
      end else if (in_data && !op_read) begin
         PORT_DATA_OUT = cur_byte;
         PORT_DATA_OE = 1'b1;
      end
      PORT_DATA_OE = PORT_DATA_OE && master_on;
   end

   // Strobe levels under polarity
   always_comb begin
      if (MASTER_MODE == PBM_MODE_COMBINED) begin
         READ_STROBE_OUT = ((state != PBM_IDLE) && op_read) ~^ READ_STROBE_POLARITY;
         WRITE_STROBE_OUT = (state == PBM_STROBE) ~^ WRITE_STROBE_POLARITY;
      end else begin
         READ_STROBE_OUT = ((state == PBM_STROBE) && op_read) ~^ READ_STROBE_POLARITY;
         WRITE_STROBE_OUT = ((state == PBM_STROBE) && !op_read) ~^ WRITE_STROBE_POLARITY;
      end
   end
   assign HIGH_BYTE_STROBE_OUT = (in_data && hi_byte) ~^ BYTE_STROBE_POLARITY;
   assign lat_lo_lvl = (state == PBM_ADDR_LO) ~^ LATCH_STROBE_POLARITY;
   assign lat_hi_lvl = (state == PBM_ADDR_HI) ~^ LATCH_STROBE_POLARITY;
   assign cs_lvl = (state != PBM_IDLE) ~^ CHIP_SELECT_POLARITY;

   // Address pin levels: latch strobes and chip select overlay address bits
   always_comb begin
      PORT_ADDR_OUT = BUS_ADDRESS_REG[PBM_ADDR_PINS-1:0];
      if (mux_addr) begin
         PORT_ADDR_OUT[PBM_LATCH_LO_PIN] = lat_lo_lvl;
      end
      if (mux_full) begin
         PORT_ADDR_OUT[PBM_LATCH_HI_PIN] = lat_hi_lvl;
      end
      if (CS_IS_SELECT) begin
         PORT_ADDR_OUT[PBM_CS_PIN] = cs_lvl;
      end
   end

   // Pin enables hand pins to the port only in master operation
   assign PORT_ADDR_OE = ADDRESS_PIN_ON & {PBM_ADDR_PINS{master_on}};
   assign READ_STROBE_OE = READ_STROBE_PIN_ON && master_on;
   assign WRITE_STROBE_OE = WRITE_STROBE_PIN_ON && master_on;
   assign HIGH_BYTE_STROBE_OE = BYTE_STROBE_PIN_ON && master_on;

   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!rst_n);

   property p_off_reverts;
      !master_on |-> (PORT_ADDR_OE == 15'h0000) && !PORT_DATA_OE && !WRITE_STROBE_OE;
   endproperty
   a_off_reverts: assert property (p_off_reverts) else $error("pins driven while off");
   property p_cs_idle;
      (state == PBM_IDLE) && CS_IS_SELECT |-> PORT_ADDR_OUT[PBM_CS_PIN] == !CHIP_SELECT_POLARITY;
   endproperty
   a_cs_idle: assert property (p_cs_idle) else $error("chip select active when idle");
   property p_demux_direct;
      start && !mux_addr |=> in_data;
   endproperty
   a_demux_direct: assert property (p_demux_direct) else $error("address phase in demux mode");
   property p_addr_lo_drive;
      state == PBM_ADDR_LO |-> PORT_DATA_OUT == BUS_ADDRESS_REG[7:0] && PORT_ADDR_OUT[0] == LATCH_STROBE_POLARITY;
   endproperty
   a_addr_lo_drive: assert property (p_addr_lo_drive) else $error("low address phase wrong");
   property p_full_order;
      start && mux_full && master_on |=> state == PBM_ADDR_LO ##1 state == PBM_ADDR_HI;
   endproperty
   a_full_order: assert property (p_full_order) else $error("full mux order wrong");
   property p_cs_zero;
      state == PBM_ADDR_HI && CS_IS_SELECT |-> !PORT_DATA_OUT[PBM_CS_HI_BIT];
   endproperty
   a_cs_zero: assert property (p_cs_zero) else $error("chip select bit not zero");
   property p_strobe_len;
      $rose(state == PBM_STROBE) && !op_read && STROBE_WAIT_COUNT == 4'h2 && master_on
         |-> (state == PBM_STROBE && !hi_byte)[*3] ##1 (state != PBM_STROBE || hi_byte);
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
   property p_step;
      fin && ADDR_STEP_MODE == PBM_STEP_INC |=> BUS_ADDRESS_REG[13:0] == $past(BUS_ADDRESS_REG[13:0]) + 14'h0001
         && (!CS_IS_SELECT || BUS_ADDRESS_REG[PBM_CS_PIN] == $past(BUS_ADDRESS_REG[PBM_CS_PIN]));
   endproperty
   a_step: assert property (p_step) else $error("address not stepped");
   property p_single_no_busy;
      start && !mux_addr && !WORD_WIDTH_SELECT && STROBE_WAIT_COUNT == 4'h0 && !DIN_READ_LO |=> !BUSY;
   endproperty
   a_single_no_busy: assert property (p_single_no_busy) else $error("busy on single cycle");
   property p_word_once;
      fin && WORD_WIDTH_SELECT |-> hi_byte;
   endproperty
   a_word_once: assert property (p_word_once) else $error("word ended after one byte");
   property p_irq;
      fin && IRQ_ENABLE |=> IRQ_PULSE ##1 !IRQ_PULSE || $past(fin);
   endproperty
   a_irq: assert property (p_irq) else $error("completion pulse missing");
   c_read: cover property (start && DIN_READ_LO && !DIN_WRITE_LO ##[1:40] fin);
   c_word_write: cover property (start && DIN_WRITE_LO && WORD_WIDTH_SELECT ##[1:80] fin);
   c_full_mux: cover property (state == PBM_ADDR_HI);
   c_stall: cover property (cap_in.valid && !cap_in.ready);
endmodule // pbm_master_engine
`default_nettype wire

/* verification/pbm_far_device.sv */
// Far-side parallel device: answers reads, logs written bytes.
// Assumes active-high strobes on the engine side.
`timescale 1ns/10ps
`default_nettype none
module pbm_far_device (
   input wire logic clk, // System clock
   input wire logic rd, // Read strobe or direction pin
   input wire logic wr, // Write or enable strobe pin
   input wire logic be, // High byte strobe pin
   input wire logic [7:0] dout, // Data pins from the port
   output logic [7:0] din, // Data pins to the port
   output logic [3:0] n_rd = 4'h0, // Completed reads
   output logic [15:0] hist = 16'h0000 // Last two written bytes
);
   logic rd_q = 1'b0; // Read strobe history
   logic wr_q = 1'b0; // Write strobe history
   logic be_q = 1'b0; // High byte strobe history
   logic [7:0] junk = 8'h00; // Undriven bus pattern, stays 8'h00 since ~0 + 1 wraps to 0
   // Drive only under the read strobe
   assign din = rd ? {4'hC, n_rd} : junk;
   // Count reads at strobe end; log a write at strobe start or when the high byte begins
   always @(posedge clk) begin
      junk <= ~junk + 8'h01;
      rd_q <= rd;
      wr_q <= wr;
      be_q <= be;
      if (!rd && rd_q) n_rd <= n_rd + 4'h1;
      if (wr && !rd && (!wr_q || (be && !be_q))) hist <= {hist[7:0], dout};
   end
endmodule // pbm_far_device
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the parallel bus master engine.
// Assumes the far device model; all control polarities active high until t_pins sets them low.
`timescale 1ns/10ps
`default_nettype none
module testbench import pbm_pkg::*;;
   logic CLK_SYS = 1'b0, RSTN = 1'b0, PORT_MODULE_ON = 1'b1, CS_IS_SELECT = 1'b1, IRQ_ENABLE = 1'b1;
   logic CHIP_SELECT_POLARITY = 1'b1, BYTE_STROBE_POLARITY = 1'b1, WRITE_STROBE_POLARITY = 1'b1;
   logic READ_STROBE_POLARITY = 1'b1, LATCH_STROBE_POLARITY = 1'b1, BYTE_STROBE_PIN_ON = 1'b1;
   logic WRITE_STROBE_PIN_ON = 1'b1, READ_STROBE_PIN_ON = 1'b1, ADDR_WRITE = 1'b0, WORD_WIDTH_SELECT = 1'b0;
   logic DIN_READ_LO = 1'b0, DIN_WRITE_LO = 1'b0, DIN_WRITE_HI = 1'b0;
   logic [1:0] MASTER_MODE = PBM_MODE_SPLIT, ADDR_MUX_SELECT = 2'h0, ADDR_STEP_MODE = 2'h0;
   logic [1:0] SETUP_WAIT_COUNT = 2'h0, HOLD_WAIT_COUNT = 2'h0;
   logic [3:0] STROBE_WAIT_COUNT = 4'h0, n_rd, k;
   logic [14:0] ADDRESS_PIN_ON = 15'h7FFF, PORT_ADDR_OUT, PORT_ADDR_OE;
   logic [15:0] ADDR_WDATA = 16'h0000, BUS_ADDRESS_REG, DATA_IN_REG, hist;
   logic [7:0] DIN_WDATA = 8'h00, PORT_DATA_IN, PORT_DATA_OUT;
   logic BUSY, IRQ_PULSE, PORT_DATA_OE, READ_STROBE_OUT, READ_STROBE_OE, WRITE_STROBE_OUT, WRITE_STROBE_OE;
   logic HIGH_BYTE_STROBE_OUT, HIGH_BYTE_STROBE_OE;
   int n_mismatch = 0, checked = 0, nb, ni, nh;
   pbm_master_engine i_dut (.*);
   pbm_far_device i_far (.clk(CLK_SYS), .rd(READ_STROBE_OUT), .wr(WRITE_STROBE_OUT), .be(HIGH_BYTE_STROBE_OUT),
      .dout(PORT_DATA_OUT),
      .din(PORT_DATA_IN), .n_rd(n_rd), .hist(hist));
   // Clock, 5 ns period
   initial forever #2.5 CLK_SYS = ~CLK_SYS;
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Load the address register
   task automatic load_addr(input logic [15:0] a);
      @(posedge CLK_SYS);
      ADDR_WRITE <= 1'b1;
      ADDR_WDATA <= a;
      @(posedge CLK_SYS);
      ADDR_WRITE <= 1'b0;
   endtask
   // Start one operation, count busy and byte strobe cycles until completion
   task automatic run_op(input bit rd);
      @(posedge CLK_SYS);
      DIN_READ_LO <= rd;
      DIN_WRITE_LO <= !rd;
      @(posedge CLK_SYS);
      DIN_READ_LO <= 1'b0;
      DIN_WRITE_LO <= 1'b0;
      nb = 0;
      ni = 0;
      nh = 0;
      for (int i = 0; i < 60 && ni == 0; i++) begin
         #1;
         nb += int'(BUSY === 1'b1);
         nh += int'(HIGH_BYTE_STROBE_OUT === 1'b1);
         ni += int'(IRQ_PULSE === 1'b1);
         @(posedge CLK_SYS);
      end
      #1;
   endtask
   // Byte write, no waits: single cycle, never busy
   task automatic t_write8;
      DIN_WDATA <= 8'h3C;
      ADDR_STEP_MODE <= PBM_STEP_INC;
      load_addr(16'h0010);
      check(16'(PORT_ADDR_OUT[PBM_CS_PIN]), 16'h0000);
      run_op(1'b0);
      check(16'(nb), 16'h0000);
      check(16'(ni), 16'h0001);
      check(16'(hist[7:0]), 16'h003C);
      check(BUS_ADDRESS_REG, 16'h0011);
   endtask
   // Word read, full mux, one wait in each part
   task automatic t_word_read;
      ADDR_MUX_SELECT <= PBM_MUX_FULL;
      WORD_WIDTH_SELECT <= 1'b1;
      ADDR_STEP_MODE <= PBM_STEP_DEC;
      SETUP_WAIT_COUNT <= 2'h1;
      STROBE_WAIT_COUNT <= 4'h1;
      HOLD_WAIT_COUNT <= 2'h1;
      load_addr(16'h0100);
      k = n_rd;
      run_op(1'b1);
      check(16'(nb), 16'd9);
      repeat (3) @(posedge CLK_SYS);
      #1;
      check(DATA_IN_REG, {4'hC, k + 4'h1, 4'hC, k});
      check(BUS_ADDRESS_REG, 16'h00FF);
   endtask
   // Word write with a start request while busy
   task automatic t_word_write_busy;
      ADDR_MUX_SELECT <= PBM_MUX_NONE;
      SETUP_WAIT_COUNT <= 2'h0;
      STROBE_WAIT_COUNT <= 4'h2;
      HOLD_WAIT_COUNT <= 2'h0;
      DIN_WRITE_HI <= 1'b1;
      DIN_WDATA <= 8'hB7;
      @(posedge CLK_SYS);
      DIN_WRITE_HI <= 1'b0;
      DIN_WDATA <= 8'h4E;
      fork
         run_op(1'b0);
         begin
            repeat (3) @(posedge CLK_SYS);
            DIN_WRITE_LO <= 1'b1;
            DIN_WDATA <= 8'h99;
            @(posedge CLK_SYS);
            DIN_WRITE_LO <= 1'b0;
         end
      join
      check(16'(nb), 16'd5);
      check(16'(nh), 16'd3);
      repeat (12) @(posedge CLK_SYS);
      check(hist, 16'h4EB7);
      check(16'(DATA_IN_REG[7:0]), 16'h004E);
   endtask
   // Combined strobes, partial mux byte read
   task automatic t_combined_read;
      MASTER_MODE <= PBM_MODE_COMBINED;
      ADDR_MUX_SELECT <= PBM_MUX_PARTIAL;
      WORD_WIDTH_SELECT <= 1'b0;
      STROBE_WAIT_COUNT <= 4'h0;
      k = n_rd;
      run_op(1'b1);
      check(16'(nb), 16'h0001);
      repeat (3) @(posedge CLK_SYS);
      check(16'(DATA_IN_REG[7:0]), {8'h00, 4'hC, k});
   endtask
   // Pin enables, inactive levels under low polarity, requests ignored while off
   task automatic t_pins;
      ADDRESS_PIN_ON <= 15'h4003;
      @(posedge CLK_SYS);
      #1;
      check({PORT_ADDR_OE, PORT_DATA_OE}, {15'h4003, 1'b0});
      check({13'h0000, READ_STROBE_OE, WRITE_STROBE_OE, HIGH_BYTE_STROBE_OE}, 16'h0007);
      @(posedge CLK_SYS);
      PORT_MODULE_ON <= 1'b0;
      {READ_STROBE_POLARITY, WRITE_STROBE_POLARITY, BYTE_STROBE_POLARITY} <= 3'h0;
      {CHIP_SELECT_POLARITY, LATCH_STROBE_POLARITY} <= 2'h0;
      run_op(1'b0);
      check({PORT_ADDR_OE, WRITE_STROBE_OE}, 16'h0000);
      check(16'(ni + nb), 16'h0000);
      check({13'h0000, READ_STROBE_OUT, WRITE_STROBE_OUT, HIGH_BYTE_STROBE_OUT}, 16'h0007);
      check({14'h0000, PORT_ADDR_OUT[PBM_CS_PIN], PORT_ADDR_OUT[PBM_LATCH_LO_PIN]}, 16'h0003);
   endtask
   // Print counts and verdict, then stop
   task automatic give_verdict;
      $display("Counts: %0d checked, %0d mismatched", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge CLK_SYS);
      RSTN <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      t_write8();
      $display("t_write8 done");
      @(posedge CLK_SYS);
      t_word_read();
      $display("t_word_read done");
      @(posedge CLK_SYS);
      t_word_write_busy();
      $display("t_word_write_busy done");
      @(posedge CLK_SYS);
      t_combined_read();
      $display("t_combined_read done");
      @(posedge CLK_SYS);
      t_pins();
      $display("t_pins done");
      give_verdict();
   end
   // Watchdog
   initial begin
      #20000;
      n_mismatch++;
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
